// File: shared/clsm_consts.svh
// constants for the closed-loop step mode controller
`ifndef CLSM_CONSTS_SVH
`define CLSM_CONSTS_SVH

// register byte offsets
`define CLSM_A_CTRL 8'h00
`define CLSM_A_OPMODE 8'h04
`define CLSM_A_TARGET 8'h08
`define CLSM_A_CMD 8'h0C
`define CLSM_A_VEL_PER 8'h10
`define CLSM_A_RUN_CUR 8'h14
`define CLSM_A_HOLD_CUR 8'h18
`define CLSM_A_HOLD_DLY 8'h1C
`define CLSM_A_TQ 8'h20
`define CLSM_A_TS 8'h24
`define CLSM_A_BOUND 8'h28
`define CLSM_A_MK_VEL 8'h2C
`define CLSM_A_POS_LIM 8'h30
`define CLSM_A_VEL_WIN 8'h34
`define CLSM_A_VEL_THR 8'h38
`define CLSM_A_STATUS 8'h3C
`define CLSM_A_LEADLAG 8'h40
`define CLSM_A_CMD_POS 8'h44
`define CLSM_A_ENC_POS 8'h48
`define CLSM_A_DEMAND 8'h4C

// field positions
`define CLSM_F_MODE 1:0
`define CLSM_F_MK_EN 2
`define CLSM_F_MK_SEL 3
`define CLSM_F_LIM_EN 4
`define CLSM_F_CMD 1:0
`define CLSM_F_SLEW_DIR 2
`define CLSM_F_LO16 15:0
`define CLSM_F_HI16 31:16
`define CLSM_F_BYTE 7:0
`define CLSM_F_STALL 2

// reset values
`define CLSM_RST_RUN_CUR 8'h50
`define CLSM_RST_HOLD_CUR 8'h20
`define CLSM_RST_HOLD_DLY 16'h00C8
`define CLSM_RST_VEL_PER 16'h0064
`define CLSM_RST_BOUND 16'h0010
`define CLSM_RST_TQ 8'h32
`define CLSM_RST_TS 16'h0032
`define CLSM_RST_MK_VEL 32'h0032_00C8
`define CLSM_RST_POS_LIM 32'h7FFF_FFFF
`define CLSM_SYNC_FULL_STEPS 2

`endif

// File: shared/clsm_pkg.sv
// types for the closed-loop step mode controller
package clsm_pkg;
	typedef enum logic [1:0] {CORR_OFF, CORR_FIXED, CORR_VAR, CORR_TORQUE}
		clsm_corr_t;
	typedef enum logic [1:0] {OP_PPOS, OP_PVEL, OP_PTRQ, OP_CSP} clsm_op_t;
	typedef enum logic [1:0] {CMD_STOP, CMD_ABS, CMD_REL, CMD_SLEW}
		clsm_cmd_t;
	typedef enum logic [1:0] {ST_IDLE, ST_MOVE, ST_SLEW, ST_MAKEUP}
		clsm_state_t;
	typedef struct packed {
		logic valid;
		logic wr;
		logic [7:0] addr;
	} clsm_aphase_t;
	typedef struct packed {
		logic step;
		logic dir;
	} clsm_step_t;
endpackage

// File: core/clsm_sync2.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/10ps
module clsm_sync2 #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_ff;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta_ff <= '0;
			q <= '0;
		end
		else
		begin
			meta_ff <= d;
			q <= meta_ff;
		end
	end
endmodule

// File: core/clsm_rate_gen.sv
// velocity generator: one pulse every period cycles while run is high
`timescale 1ns/10ps
module clsm_rate_gen #(
	parameter int W = 16
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic run,
	input wire logic [W-1:0] period,
	output logic pulse
);
	logic [W-1:0] cnt_ff;

	// a period of zero behaves as one so the generator never stalls
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt_ff <= '0;
			pulse <= 1'b0;
		end
		else if (!run)
		begin
			cnt_ff <= '0;
			pulse <= 1'b0;
		end
		else if (cnt_ff + W'(1) >= period)
		begin
			cnt_ff <= '0;
			pulse <= 1'b1;
		end
		else
		begin
			cnt_ff <= cnt_ff + W'(1);
			pulse <= 1'b0;
		end
	end
endmodule

// File: core/clsm_ctrl.sv
// closed-loop step mode controller with AHB-Lite register slave
`timescale 1ns/10ps
`include "clsm_consts.svh"
// How it works
// - synchronous while lead/lag within two full steps
// - four correction modes: off, fixed, variable, torque
// - correction mode changes only while no move
// - correction off passes commands straight to motor
// - correction off uses fixed run/hold current
// - stall check and position kept without correction
// - encoder compared with pulses, lead/lag bounded while correction is on
// - lead/lag register accumulates, feeds make-up move
// - make-up reinserts pulses at one of two presets
// - fixed correction uses run and hold current
// - variable current scales with load, capped run
// - torque mode holds torque, limits speed
// - profile torque forces torque correction mode
// - no encoder: fixed current, no correction, no torque
// - current from run, hold, delay, fixed/variable
// - profile position limits target into increments
// - profile velocity window and threshold monitoring
// - cyclic position takes master targets each cycle
module clsm_ctrl #(
	parameter int USTEP_PER_FULL = 16,
	parameter int VEL_WIN_CYC = 1000
) (
	input wire logic CLK,
	input wire logic RESETN,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic HREADYOUT,
	output logic [31:0] HRDATA,
	output logic HRESP,
	input wire logic ENC_FITTED,
	input wire logic ENC_STEP,
	input wire logic ENC_DIR,
	output clsm_pkg::clsm_step_t MOTOR,
	output logic [7:0] CURRENT_PCT,
	output logic SYNC_OK,
	output logic MOVING
);
	import clsm_pkg::*;

	localparam logic [31:0] SYNC_LIM =
		32'(`CLSM_SYNC_FULL_STEPS * USTEP_PER_FULL);

	clsm_aphase_t dp_ff;
	clsm_corr_t corr_mode_ff;
	clsm_op_t op_mode_ff;
	clsm_state_t state_ff;
	logic mk_en_ff, mk_sel_ff, lim_en_ff, stall_ff, slew_dir_ff;
	logic [31:0] target_ff, mk_vel_ff, pos_lim_ff, vel_win_ff, mk_cnt_ff;
	logic [15:0] vel_per_ff, hold_dly_ff, ts_ff, bound_ff, vel_thr_ff;
	logic [15:0] idle_cnt_ff, enc_cnt_ff, act_vel_ff;
	logic [31:0] win_cnt_ff;
	logic [7:0] run_cur_ff, hold_cur_ff, tq_ff, nxt_cur;
	logic signed [31:0] cmd_pos_ff, demand_ff, enc_pos_ff, leadlag_ff;
	logic [1:0] enc_s;
	logic enc_step_d_ff, enc_evt, enc_fitted;
	logic gen_pulse, wr_en, rd_en, busy, corr_on, cmd_step, cmd_dir;
	logic start_move, csp_update;
	logic signed [31:0] nxt_demand;
	logic [15:0] gen_period, vel_err;
	logic [31:0] ll_mag;
	clsm_corr_t eff_corr;

	function automatic logic [31:0] mag32(input logic signed [31:0] v);
		mag32 = v[31] ? 32'(-v) : 32'(v);
	endfunction

	function automatic logic signed [31:0] clamp_pos(
		input logic signed [31:0] v, input logic [31:0] lim);
		logic signed [31:0] l;
		l = $signed(lim);
		if (v > l)
			clamp_pos = l;
		else if (v < -l)
			clamp_pos = -l;
		else
			clamp_pos = v;
	endfunction

	clsm_sync2 #(.W(2)) u_sync_enc (
		.clk(CLK),
		.rst_n(RESETN),
		.d({ENC_DIR, ENC_STEP}),
		.q(enc_s)
	);

	clsm_sync2 #(.W(1)) u_sync_fit (
		.clk(CLK),
		.rst_n(RESETN),
		.d(ENC_FITTED),
		.q(enc_fitted)
	);

	clsm_rate_gen #(.W(16)) u_gen (
		.clk(CLK),
		.rst_n(RESETN),
		.run(state_ff != ST_IDLE),
		.period(gen_period),
		.pulse(gen_pulse)
	);

	assign HREADYOUT = 1'b1;
	assign HRESP = 1'b0;
	assign busy = (state_ff != ST_IDLE);
	assign MOVING = busy;
	assign ll_mag = mag32(leadlag_ff);
	assign wr_en = dp_ff.valid && dp_ff.wr;
	assign rd_en = HSEL && HTRANS[1] && HREADY && !HWRITE;
	assign enc_evt = enc_s[0] && !enc_step_d_ff;

	// encoderless units never leave correction off
	always_comb
	begin
		if (!enc_fitted)
			eff_corr = CORR_OFF;
		else if (op_mode_ff == OP_PTRQ)
			eff_corr = CORR_TORQUE;
		else
			eff_corr = corr_mode_ff;
	end
	assign corr_on = (eff_corr != CORR_OFF);

	// torque speed limit is the shortest allowed pulse period
	always_comb
	begin
		if (state_ff == ST_MAKEUP)
			gen_period = mk_sel_ff ? mk_vel_ff[`CLSM_F_HI16] :
				mk_vel_ff[`CLSM_F_LO16];
		else if (eff_corr == CORR_TORQUE && vel_per_ff < ts_ff)
			gen_period = ts_ff;
		else
			gen_period = vel_per_ff;
	end

	// address phase capture; every transfer is zero wait state
	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
			dp_ff <= '0;
		else
		begin
			dp_ff.valid <= HSEL && HTRANS[1] && HREADY;
			dp_ff.wr <= HWRITE;
			dp_ff.addr <= HADDR[7:0];
		end
	end

	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
			HRDATA <= 32'h0000_0000;
		else if (rd_en)
		begin
			if (HADDR[7:0] == `CLSM_A_CTRL)
				HRDATA <= {27'h000_0000, lim_en_ff, mk_sel_ff, mk_en_ff,
					corr_mode_ff};
			else if (HADDR[7:0] == `CLSM_A_OPMODE)
				HRDATA <= {30'h0000_0000, op_mode_ff};
			else if (HADDR[7:0] == `CLSM_A_TARGET)
				HRDATA <= target_ff;
			else if (HADDR[7:0] == `CLSM_A_VEL_PER)
				HRDATA <= {16'h0000, vel_per_ff};
			else if (HADDR[7:0] == `CLSM_A_RUN_CUR)
				HRDATA <= {24'h00_0000, run_cur_ff};
			else if (HADDR[7:0] == `CLSM_A_HOLD_CUR)
				HRDATA <= {24'h00_0000, hold_cur_ff};
			else if (HADDR[7:0] == `CLSM_A_HOLD_DLY)
				HRDATA <= {16'h0000, hold_dly_ff};
			else if (HADDR[7:0] == `CLSM_A_TQ)
				HRDATA <= {24'h00_0000, tq_ff};
			else if (HADDR[7:0] == `CLSM_A_TS)
				HRDATA <= {16'h0000, ts_ff};
			else if (HADDR[7:0] == `CLSM_A_BOUND)
				HRDATA <= {16'h0000, bound_ff};
			else if (HADDR[7:0] == `CLSM_A_MK_VEL)
				HRDATA <= mk_vel_ff;
			else if (HADDR[7:0] == `CLSM_A_POS_LIM)
				HRDATA <= pos_lim_ff;
			else if (HADDR[7:0] == `CLSM_A_VEL_WIN)
				HRDATA <= vel_win_ff;
			else if (HADDR[7:0] == `CLSM_A_VEL_THR)
				HRDATA <= {16'h0000, vel_thr_ff};
			else if (HADDR[7:0] == `CLSM_A_STATUS)
				HRDATA <= {18'h0_0000, state_ff, 2'b00, eff_corr, 2'b00,
					enc_fitted,
					act_vel_ff > vel_thr_ff, vel_err <= vel_win_ff[15:0],
					stall_ff, SYNC_OK, busy};
			else if (HADDR[7:0] == `CLSM_A_LEADLAG)
				HRDATA <= leadlag_ff;
			else if (HADDR[7:0] == `CLSM_A_CMD_POS)
				HRDATA <= cmd_pos_ff;
			else if (HADDR[7:0] == `CLSM_A_ENC_POS)
				HRDATA <= enc_pos_ff;
			else if (HADDR[7:0] == `CLSM_A_DEMAND)
				HRDATA <= demand_ff;
			else
				HRDATA <= 32'h0000_0000;
		end
	end

	// configuration registers
	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			corr_mode_ff <= CORR_OFF;
			op_mode_ff <= OP_PPOS;
			{mk_en_ff, mk_sel_ff, lim_en_ff} <= 3'b000;
			target_ff <= 32'h0000_0000;
			vel_per_ff <= `CLSM_RST_VEL_PER;
			run_cur_ff <= `CLSM_RST_RUN_CUR;
			hold_cur_ff <= `CLSM_RST_HOLD_CUR;
			hold_dly_ff <= `CLSM_RST_HOLD_DLY;
			tq_ff <= `CLSM_RST_TQ;
			ts_ff <= `CLSM_RST_TS;
			bound_ff <= `CLSM_RST_BOUND;
			mk_vel_ff <= `CLSM_RST_MK_VEL;
			pos_lim_ff <= `CLSM_RST_POS_LIM;
			vel_win_ff <= 32'h0000_0000;
			vel_thr_ff <= 16'h0000;
		end
		else if (wr_en)
		begin
			if (dp_ff.addr == `CLSM_A_CTRL)
			begin
				mk_en_ff <= HWDATA[`CLSM_F_MK_EN];
				mk_sel_ff <= HWDATA[`CLSM_F_MK_SEL];
				lim_en_ff <= HWDATA[`CLSM_F_LIM_EN];
				if (!busy)
					corr_mode_ff <= clsm_corr_t'(HWDATA[`CLSM_F_MODE]);
			end
			else if (dp_ff.addr == `CLSM_A_OPMODE)
			begin
				if (!busy && (enc_fitted ||
					clsm_op_t'(HWDATA[`CLSM_F_MODE]) != OP_PTRQ))
					op_mode_ff <= clsm_op_t'(HWDATA[`CLSM_F_MODE]);
			end
			else if (dp_ff.addr == `CLSM_A_TARGET)
				target_ff <= HWDATA;
			else if (dp_ff.addr == `CLSM_A_VEL_PER)
				vel_per_ff <= HWDATA[`CLSM_F_LO16];
			else if (dp_ff.addr == `CLSM_A_RUN_CUR)
				run_cur_ff <= HWDATA[`CLSM_F_BYTE];
			else if (dp_ff.addr == `CLSM_A_HOLD_CUR)
				hold_cur_ff <= HWDATA[`CLSM_F_BYTE];
			else if (dp_ff.addr == `CLSM_A_HOLD_DLY)
				hold_dly_ff <= HWDATA[`CLSM_F_LO16];
			else if (dp_ff.addr == `CLSM_A_TQ)
				tq_ff <= HWDATA[`CLSM_F_BYTE];
			else if (dp_ff.addr == `CLSM_A_TS)
				ts_ff <= HWDATA[`CLSM_F_LO16];
			else if (dp_ff.addr == `CLSM_A_BOUND)
				bound_ff <= HWDATA[`CLSM_F_LO16];
			else if (dp_ff.addr == `CLSM_A_MK_VEL)
				mk_vel_ff <= HWDATA;
			else if (dp_ff.addr == `CLSM_A_POS_LIM)
				pos_lim_ff <= HWDATA;
			else if (dp_ff.addr == `CLSM_A_VEL_WIN)
				vel_win_ff <= HWDATA;
			else if (dp_ff.addr == `CLSM_A_VEL_THR)
				vel_thr_ff <= HWDATA[`CLSM_F_LO16];
		end
	end

	// new demand from a command write, or from a target in cyclic mode
	assign csp_update = wr_en && dp_ff.addr == `CLSM_A_TARGET &&
		op_mode_ff == OP_CSP;
	assign start_move = (wr_en && dp_ff.addr == `CLSM_A_CMD &&
		clsm_cmd_t'(HWDATA[`CLSM_F_CMD]) != CMD_STOP) ||
		(csp_update && state_ff == ST_IDLE);
	always_comb
	begin
		if (csp_update)
			nxt_demand = $signed(HWDATA);
		else if (clsm_cmd_t'(HWDATA[`CLSM_F_CMD]) == CMD_REL)
			nxt_demand = cmd_pos_ff + (lim_en_ff ?
				clamp_pos($signed(target_ff), pos_lim_ff) :
				$signed(target_ff));
		else
			nxt_demand = lim_en_ff ? clamp_pos($signed(target_ff),
				pos_lim_ff) : $signed(target_ff);
	end

	// with correction on, a commanded step is held back while the lead/lag sits at the bound
	assign cmd_dir = (state_ff == ST_SLEW) ? slew_dir_ff :
		(demand_ff > cmd_pos_ff);
	assign cmd_step = gen_pulse && (state_ff == ST_SLEW ||
		(state_ff == ST_MOVE && cmd_pos_ff != demand_ff)) &&
		(!corr_on || ll_mag < 32'(bound_ff));

	// move sequencer
	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			state_ff <= ST_IDLE;
			demand_ff <= 32'sh0000_0000;
			cmd_pos_ff <= 32'sh0000_0000;
			slew_dir_ff <= 1'b0;
			mk_cnt_ff <= 32'h0000_0000;
			MOTOR <= '0;
		end
		else
		begin
			MOTOR.step <= 1'b0;
			if (wr_en && dp_ff.addr == `CLSM_A_CMD &&
				clsm_cmd_t'(HWDATA[`CLSM_F_CMD]) == CMD_STOP)
				state_ff <= ST_IDLE;
			else if (start_move)
			begin
				demand_ff <= nxt_demand;
				slew_dir_ff <= HWDATA[`CLSM_F_SLEW_DIR];
				state_ff <= (!csp_update &&
					clsm_cmd_t'(HWDATA[`CLSM_F_CMD]) == CMD_SLEW) ?
					ST_SLEW : ST_MOVE;
			end
			else if (csp_update)
				demand_ff <= nxt_demand;
			else
			begin
				case (state_ff)
					ST_MOVE, ST_SLEW:
					begin
						if (cmd_step)
						begin
							cmd_pos_ff <= cmd_dir ? cmd_pos_ff + 32'sd1 :
								cmd_pos_ff - 32'sd1;
							MOTOR.step <= 1'b1;
							MOTOR.dir <= cmd_dir;
						end
						else if (state_ff == ST_MOVE && cmd_pos_ff == demand_ff)
						begin
							if (corr_on && mk_en_ff && leadlag_ff != 32'sd0)
							begin
								mk_cnt_ff <= ll_mag;
								state_ff <= ST_MAKEUP;
							end
							else
								state_ff <= ST_IDLE;
						end
					end
					ST_MAKEUP:
					begin
						if (mk_cnt_ff == 32'h0000_0000)
							state_ff <= ST_IDLE;
						else if (gen_pulse)
						begin
							// positive lead/lag: rotor behind, step forward
							MOTOR.step <= 1'b1;
							MOTOR.dir <= !leadlag_ff[31];
							mk_cnt_ff <= mk_cnt_ff - 32'h0000_0001;
						end
					end
					default:
						state_ff <= ST_IDLE;
				endcase
			end
		end
	end

	// encoder position and lead/lag accounting
	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			enc_step_d_ff <= 1'b0;
			enc_pos_ff <= 32'sh0000_0000;
			leadlag_ff <= 32'sh0000_0000;
		end
		else
		begin
			enc_step_d_ff <= enc_s[0];
			if (enc_evt)
				enc_pos_ff <= enc_s[1] ? enc_pos_ff + 32'sd1 :
					enc_pos_ff - 32'sd1;
			if (start_move && !csp_update)
				leadlag_ff <= 32'sh0000_0000;
			else if (enc_fitted)
				leadlag_ff <= leadlag_ff +
					(cmd_step ? (cmd_dir ? 32'sd1 : -32'sd1) : 32'sd0) -
					(enc_evt ? (enc_s[1] ? 32'sd1 : -32'sd1) : 32'sd0);
		end
	end

	assign SYNC_OK = (ll_mag <= SYNC_LIM);

	// stall flag: write one to clear, a new stall in the same cycle wins
	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
			stall_ff <= 1'b0;
		else if (enc_fitted && !corr_on && ll_mag > 32'(bound_ff))
			stall_ff <= 1'b1;
		else if (wr_en && dp_ff.addr == `CLSM_A_STATUS &&
			HWDATA[`CLSM_F_STALL])
			stall_ff <= 1'b0;
	end

	// bridge current; in off and fixed modes hold current only after the delay has run out
	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
			idle_cnt_ff <= 16'h0000;
		else if (busy)
			idle_cnt_ff <= 16'h0000;
		else if (idle_cnt_ff < hold_dly_ff)
			idle_cnt_ff <= idle_cnt_ff + 16'h0001;
	end

	always_comb
	begin
		case (eff_corr)
			CORR_VAR:
			begin
				// hold level plus lead/lag magnitude, never above run
				if (ll_mag >= 32'(run_cur_ff) ||
					ll_mag[7:0] >= run_cur_ff - hold_cur_ff)
					nxt_cur = run_cur_ff;
				else
					nxt_cur = hold_cur_ff + ll_mag[7:0];
			end
			CORR_TORQUE:
				nxt_cur = tq_ff;
			default:
				nxt_cur = (busy || idle_cnt_ff < hold_dly_ff) ?
					run_cur_ff : hold_cur_ff;
		endcase
	end

	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
			CURRENT_PCT <= 8'h00;
		else
			CURRENT_PCT <= nxt_cur;
	end

	// measured speed: encoder counts per window, latched at window end
	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			win_cnt_ff <= 32'h0000_0000;
			enc_cnt_ff <= 16'h0000;
			act_vel_ff <= 16'h0000;
		end
		else if (win_cnt_ff >= 32'(VEL_WIN_CYC - 1))
		begin
			win_cnt_ff <= 32'h0000_0000;
			act_vel_ff <= enc_cnt_ff;
			enc_cnt_ff <= 16'h0000;
		end
		else
		begin
			win_cnt_ff <= win_cnt_ff + 32'h0000_0001;
			if (enc_evt)
				enc_cnt_ff <= enc_cnt_ff + 16'h0001;
		end
	end

	assign vel_err = (act_vel_ff > vel_win_ff[`CLSM_F_HI16]) ?
		act_vel_ff - vel_win_ff[`CLSM_F_HI16] :
		vel_win_ff[`CLSM_F_HI16] - act_vel_ff;
endmodule

// File: sim/clsm_ctrl_checker.sv
// assertion checker for the closed-loop step mode controller
`timescale 1ns/10ps
`include "clsm_consts.svh"
module clsm_ctrl_checker (
	input wire logic CLK,
	input wire logic RESETN,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	input wire logic [31:0] HRDATA,
	input wire logic ENC_FITTED,
	input wire clsm_pkg::clsm_step_t MOTOR,
	input wire logic [7:0] CURRENT_PCT,
	input wire logic SYNC_OK,
	input wire logic MOVING
);
	import clsm_pkg::*;
	logic ap_ff, wr_ff, enc_ff, rd_go;
	logic [7:0] ad_ff, run_ff, tq_ff;
	logic [1:0] mode_ff, op_ff, settle_ff, eff_mode;
	assign rd_go = HSEL && HTRANS[1] && HREADY && !HWRITE;
	// lagged strap so a fresh edge is not judged before it is synced
	assign eff_mode = !enc_ff ? 2'h0 : (op_ff == 2'h2 ? 2'h3 : mode_ff);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RESETN);
	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			ap_ff <= 1'b0;
			wr_ff <= 1'b0;
			ad_ff <= 8'h00;
			enc_ff <= 1'b0;
		end
		else
		begin
			ap_ff <= HSEL && HTRANS[1] && HREADY;
			wr_ff <= HWRITE;
			ad_ff <= HADDR[7:0];
			enc_ff <= ENC_FITTED;
		end
	end
	// shadow copies of the settings that decide the current
	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			run_ff <= `CLSM_RST_RUN_CUR;
			tq_ff <= `CLSM_RST_TQ;
			mode_ff <= 2'h0;
			op_ff <= 2'h0;
		end
		else if (ap_ff && wr_ff)
		begin
			case (ad_ff)
				`CLSM_A_RUN_CUR: run_ff <= HWDATA[7:0];
				`CLSM_A_TQ: tq_ff <= HWDATA[7:0];
				`CLSM_A_CTRL: if (!MOVING) mode_ff <= HWDATA[1:0];
				`CLSM_A_OPMODE:
					if (!MOVING && (HWDATA[1:0] != 2'h2 || ENC_FITTED))
						op_ff <= HWDATA[1:0];
				default: ;
			endcase
		end
	end
	// current is registered, so judge it only once writes have settled
	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
			settle_ff <= 2'h0;
		else if ((ap_ff && wr_ff) || ENC_FITTED != enc_ff)
			settle_ff <= 2'h0;
		else if (settle_ff != 2'h3)
			settle_ff <= settle_ff + 2'h1;
	end
	AST_SYNC_RPT: assert property (
		rd_go && HADDR[7:0] == `CLSM_A_STATUS
		|=> HRDATA[1:0] == {$past(SYNC_OK), $past(MOVING)})
		else $error("status bits differ from pins");
	AST_MODE_LOCK: assert property (
		rd_go && HADDR[7:0] == `CLSM_A_CTRL |=> HRDATA[1:0] == $past(mode_ff))
		else $error("mode changed during a move");
	AST_EFF_MODE: assert property (
		rd_go && HADDR[7:0] == `CLSM_A_STATUS && settle_ff == 2'h3
		|=> HRDATA[9:8] == $past(eff_mode))
		else $error("effective mode wrong");
	AST_SLEW_GO: assert property (
		ap_ff && wr_ff && ad_ff == `CLSM_A_CMD && HWDATA[1:0] == 2'h3
		|=> MOVING)
		else $error("slew did not start");
	AST_STOP: assert property (
		ap_ff && wr_ff && ad_ff == `CLSM_A_CMD && HWDATA[1:0] == 2'h0
		|-> ##[1:2] !MOVING)
		else $error("stop did not end motion");
	AST_IDLE_QUIET: assert property (
		!MOVING && !$past(MOVING) |-> !MOTOR.step)
		else $error("step while idle");
	AST_CUR_FIXED: assert property (
		settle_ff == 2'h3 && eff_mode[1] == 1'b0 && MOVING
		&& $past(MOVING) && $past(MOVING, 2) |-> CURRENT_PCT == run_ff)
		else $error("run current not applied");
	AST_CUR_VAR: assert property (
		settle_ff == 2'h3 && eff_mode == 2'h2 |-> CURRENT_PCT <= run_ff)
		else $error("variable current above run");
	AST_CUR_TQ: assert property (
		settle_ff == 2'h3 && eff_mode == 2'h3 |-> CURRENT_PCT == tq_ff)
		else $error("torque current wrong");
endmodule
bind clsm_ctrl clsm_ctrl_checker i_chk (.CLK(CLK), .RESETN(RESETN),
	.HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
	.HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA),
	.ENC_FITTED(ENC_FITTED), .MOTOR(MOTOR), .CURRENT_PCT(CURRENT_PCT),
	.SYNC_OK(SYNC_OK), .MOVING(MOVING));

// File: sim/clsm_motor_model.sv
// motor and encoder model that echoes steps back as encoder counts
`timescale 1ns/10ps
module clsm_motor_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire clsm_pkg::clsm_step_t motor,
	input wire logic slip,
	output logic enc_step,
	output logic enc_dir
);
	import clsm_pkg::*;
	logic [1:0] hold_ff;
	// slip drops the echo, like a rotor no longer following the stator
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			hold_ff <= 2'h0;
			enc_step <= 1'b0;
			enc_dir <= 1'b0;
		end
		else if (motor.step && !slip)
		begin
			hold_ff <= 2'h2;
			enc_step <= 1'b1;
			enc_dir <= motor.dir;
		end
		else if (hold_ff == 2'h2)
			hold_ff <= 2'h1;
		else if (hold_ff == 2'h1)
		begin
			hold_ff <= 2'h0;
			enc_step <= 1'b0;
			// direction is not held outside a count
			enc_dir <= ~enc_dir;
		end
	end
endmodule

// File: sim/clsm_ctrl_bench.sv
// self-checking bench for the closed-loop step mode controller
`timescale 1ns/10ps
`include "clsm_consts.svh"
module clsm_ctrl_bench;
	import clsm_pkg::*;
	logic CLK, RESETN, HSEL, HWRITE, HREADYOUT, HRESP, SYNC_OK, MOVING;
	logic ENC_FITTED, slip, enc_step, enc_dir, last_dir;
	logic [1:0] HTRANS;
	logic [31:0] HADDR, HWDATA, HRDATA, rd;
	logic [7:0] CURRENT_PCT;
	clsm_step_t MOTOR;
	int error_cnt, checked, steps, cyc, last_t, gap, base;
	clsm_ctrl #(.VEL_WIN_CYC(20)) i_dut (.CLK(CLK), .RESETN(RESETN),
		.HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
		.HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT),
		.HREADYOUT(HREADYOUT), .HRDATA(HRDATA), .HRESP(HRESP),
		.ENC_FITTED(ENC_FITTED), .ENC_STEP(enc_step), .ENC_DIR(enc_dir),
		.MOTOR(MOTOR), .CURRENT_PCT(CURRENT_PCT), .SYNC_OK(SYNC_OK),
		.MOVING(MOVING));
	clsm_motor_model i_motor (.clk(CLK), .rst_n(RESETN), .motor(MOTOR),
		.slip(slip), .enc_step(enc_step), .enc_dir(enc_dir));
	initial
	begin
		CLK = 1'b0;
		forever #5 CLK = ~CLK;
	end
	always @(posedge CLK)
	begin
		cyc <= cyc + 1;
		if (MOTOR.step === 1'b1)
		begin
			steps <= steps + 1;
			gap <= cyc - last_t;
			last_t <= cyc;
			last_dir <= MOTOR.dir;
		end
	end
	task automatic final_report;
		if (error_cnt == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge CLK);
		HSEL <= 1'b1;
		HTRANS <= 2'h2;
		HWRITE <= w;
		HADDR <= {24'h00_0000, a};
		do @(posedge CLK); while (HREADYOUT !== 1'b1);
		HSEL <= 1'b0;
		HTRANS <= 2'h0;
		HWDATA <= d;
		do @(posedge CLK); while (HREADYOUT !== 1'b1);
		rd = HRDATA;
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask
	task automatic idle_wait;
		repeat (3) @(posedge CLK);
		while (MOVING !== 1'b0) @(posedge CLK);
	endtask
	task automatic move(input logic [31:0] t, input logic [1:0] c);
		base = steps;
		bus(1'b1, `CLSM_A_TARGET, t);
		bus(1'b1, `CLSM_A_CMD, {30'h0, c});
		idle_wait;
	endtask
	task automatic t_reset;
		rdchk(`CLSM_A_RUN_CUR, 32'h50);
		rdchk(`CLSM_A_HOLD_CUR, 32'h20);
		rdchk(`CLSM_A_HOLD_DLY, 32'hC8);
		rdchk(`CLSM_A_MK_VEL, 32'h0032_00C8);
		bus(1'b1, `CLSM_A_VEL_PER, 32'h4);
		bus(1'b1, `CLSM_A_HOLD_DLY, 32'h14);
	endtask
	task automatic t_bypass;
		move(32'h3, 2'h2);
		chk(steps - base, 3);
		chk(last_dir, 1'b1);
		rdchk(`CLSM_A_CMD_POS, 32'h3);
		repeat (25) @(posedge CLK);
		rdchk(`CLSM_A_LEADLAG, 32'h0);
		chk(CURRENT_PCT, 8'h20);
		move(32'h0, 2'h1);
		chk(steps - base, 3);
		chk(last_dir, 1'b0);
	endtask
	task automatic t_stall;
		slip <= 1'b1;
		move(32'h28, 2'h2);
		chk(SYNC_OK, 1'b0);
		rdchk(`CLSM_A_LEADLAG, 32'h28);
		bus(1'b0, `CLSM_A_STATUS, 32'h0);
		chk(rd[2], 1'b1);
	endtask
	task automatic t_var;
		bus(1'b1, `CLSM_A_CTRL, 32'h2);
		repeat (4) @(posedge CLK);
		chk(CURRENT_PCT, 8'h48);
		bus(1'b1, `CLSM_A_RUN_CUR, 32'h30);
		repeat (4) @(posedge CLK);
		chk(CURRENT_PCT, 8'h30);
		bus(1'b1, `CLSM_A_RUN_CUR, 32'h50);
		bus(1'b0, `CLSM_A_STATUS, 32'h0);
		chk(rd[9:8], 2'h2);
	endtask
	task automatic t_lock;
		slip <= 1'b0;
		bus(1'b1, `CLSM_A_CMD, 32'h3);
		bus(1'b1, `CLSM_A_CTRL, 32'h1);
		rdchk(`CLSM_A_CTRL, 32'h2);
		bus(1'b1, `CLSM_A_CMD, 32'h0);
		idle_wait;
		bus(1'b1, `CLSM_A_CTRL, 32'h5);
		rdchk(`CLSM_A_CTRL, 32'h5);
	endtask
	task automatic t_makeup;
		slip <= 1'b1;
		move(32'h5, 2'h2);
		chk(steps - base, 10);
		chk(gap, 200);
		chk(last_dir, 1'b1);
		bus(1'b1, `CLSM_A_CTRL, 32'hD);
		move(32'h2, 2'h2);
		chk(gap, 50);
		bus(1'b1, `CLSM_A_CTRL, 32'h1);
		bus(1'b1, `CLSM_A_BOUND, 32'h4);
		base = steps;
		bus(1'b1, `CLSM_A_TARGET, 32'hA);
		bus(1'b1, `CLSM_A_CMD, 32'h2);
		repeat (200) @(posedge CLK);
		chk(steps - base, 4);
		bus(1'b1, `CLSM_A_CMD, 32'h0);
		idle_wait;
		bus(1'b1, `CLSM_A_BOUND, 32'h10);
	endtask
	task automatic t_torque;
		slip <= 1'b0;
		bus(1'b1, `CLSM_A_TS, 32'hC);
		bus(1'b1, `CLSM_A_OPMODE, 32'h2);
		bus(1'b0, `CLSM_A_STATUS, 32'h0);
		chk(rd[9:8], 2'h3);
		chk(CURRENT_PCT, 8'h32);
		bus(1'b1, `CLSM_A_CMD, 32'h3);
		repeat (60) @(posedge CLK);
		chk(gap, 12);
		bus(1'b0, `CLSM_A_STATUS, 32'h0);
		chk(rd[4:3], 2'h2);
		bus(1'b1, `CLSM_A_CMD, 32'h0);
		idle_wait;
		bus(1'b1, `CLSM_A_OPMODE, 32'h0);
	endtask
	task automatic t_noenc;
		ENC_FITTED <= 1'b0;
		repeat (5) @(posedge CLK);
		bus(1'b1, `CLSM_A_OPMODE, 32'h2);
		rdchk(`CLSM_A_OPMODE, 32'h0);
		bus(1'b0, `CLSM_A_STATUS, 32'h0);
		chk(rd[9:8], 2'h0);
		move(32'h3, 2'h2);
		repeat (25) @(posedge CLK);
		chk(CURRENT_PCT, 8'h20);
		bus(1'b1, `CLSM_A_POS_LIM, 32'h2);
		bus(1'b1, `CLSM_A_CTRL, 32'h10);
		move(32'h5, 2'h1);
		rdchk(`CLSM_A_CMD_POS, 32'h2);
		bus(1'b1, `CLSM_A_OPMODE, 32'h3);
		bus(1'b1, `CLSM_A_TARGET, 32'h7);
		idle_wait;
		rdchk(`CLSM_A_CMD_POS, 32'h7);
	endtask
	initial
	begin
		RESETN = 1'b0;
		HSEL = 1'b0;
		HTRANS = 2'h0;
		HWRITE = 1'b0;
		HADDR = 32'h0;
		HWDATA = 32'h0;
		ENC_FITTED = 1'b1;
		slip = 1'b0;
		repeat (5) @(posedge CLK);
		RESETN <= 1'b1;
		repeat (3) @(posedge CLK);
		t_reset;
		t_bypass;
		t_stall;
		t_var;
		t_lock;
		t_makeup;
		t_torque;
		t_noenc;
		final_report;
	end
	initial
	begin
		repeat (20000) @(posedge CLK);
		error_cnt++;
		final_report;
	end
endmodule
